// >>> hw/rfb_pkg.sv
// rfb_pkg: register map, field positions and carrier types for the
// receive free-buffer accounting and mac configuration block.
// assumes a single 100 MHz clock domain and an ahb-lite register bus.
package rfb_pkg;

  // ==========================================================
  // sizes
  localparam int unsigned RFB_CHANNELS = 8;
  localparam int unsigned RFB_CNT_W = 16;
  localparam int unsigned RFB_THR_W = 8;

  // ==========================================================
  // register byte offsets
  localparam logic [11:0] RFB_FREE_BASE = 12'h0_000;
  localparam logic [11:0] RFB_FLOW_BASE = 12'h0_020;
  localparam logic [11:0] RFB_FILT_OFF = 12'h0_040;
  localparam logic [11:0] RFB_CFG_OFF = 12'h0_044;
  localparam logic [11:0] RFB_STAT_OFF = 12'h0_048;
  localparam logic [11:0] RFB_PRESS_OFF = 12'h0_04c;
  localparam logic [11:0] RFB_CHAN_STRIDE = 12'h0_004;

  // ==========================================================
  // configuration register fields
  localparam int unsigned RFB_CFG_W = 15;
  localparam logic [RFB_CFG_W-1:0] RFB_CFG_RESET = 15'h0_000;
  localparam int unsigned RFB_B_OFFLEN = 14;
  localparam int unsigned RFB_B_OWNER = 13;
  localparam int unsigned RFB_B_FIFOPAUSE = 12;
  localparam int unsigned RFB_B_IDLE = 11;
  localparam int unsigned RFB_B_TXPOL = 9;
  localparam int unsigned RFB_B_PACE = 6;
  localparam int unsigned RFB_B_MII = 5;
  localparam int unsigned RFB_B_PAUSEHON = 4;
  localparam int unsigned RFB_B_BUFFLOW = 3;
  localparam int unsigned RFB_B_LOOP = 1;
  localparam int unsigned RFB_B_FDX = 0;
  // writable bits: 14..11, 9, 6..3, 1, 0
  localparam logic [RFB_CFG_W-1:0] RFB_CFG_MASK = 15'h7_a7b;

  // status register field
  localparam int unsigned RFB_S_IDLE = 0;

  // ==========================================================
  // carrier types
  typedef struct packed {
    logic offlen_block;
    logic owner_value;
    logic fifo_pause;
    logic idle_req;
    logic tx_fixed_prio;
    logic tx_pace;
    logic mii_enable;
    logic pause_honor;
    logic buf_flow;
    logic loopback;
    logic fdx;
  } rfb_ctl_t;

  typedef struct packed {
    logic valid;
    logic [$clog2(RFB_CHANNELS)-1:0] chan;
    logic [RFB_CNT_W-1:0] used;
  } rfb_frame_t;

endpackage : rfb_pkg

// >>> hw/rfb_ahb_slave.sv
// rfb_ahb_slave: ahb-lite single-word slave front end.
// assumes whole-word single transfers; always answers okay, no waits.
`timescale 1ns/10ps
module rfb_ahb_slave (
  input wire logic clock,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic wr_en,
  output logic rd_en,
  output logic [11:0] acc_addr
);
  import rfb_pkg::*;

  // ==========================================================
  // address phase capture
  logic ph_wr;
  logic [11:0] ph_addr;
  logic take;

  assign take = hsel & hready & htrans[1];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ph_wr <= 1'b0;
      ph_addr <= 12'h0_000;
    end else begin
      ph_wr <= take & hwrite;
      if (take) begin
        ph_addr <= {haddr[11:2], 2'b00};
      end
    end
  end

  assign wr_en = ph_wr;
  assign rd_en = take & ~hwrite;
  assign acc_addr = ph_wr ? ph_addr : {haddr[11:2], 2'b00};
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule : rfb_ahb_slave

// >>> hw/rfb_free_counter.sv
// rfb_free_counter: one channel's free-buffer count.
// assumes host add and frame subtract may land in the same cycle.
`timescale 1ns/10ps
module rfb_free_counter #(
  parameter int unsigned CNT_W = 16
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic add_en,
  input wire logic [CNT_W-1:0] add_val,
  input wire logic sub_en,
  input wire logic [CNT_W-1:0] sub_val,
  output logic [CNT_W-1:0] count
);
  import rfb_pkg::*;

  logic [CNT_W-1:0] next_count;

  // ==========================================================
  // modulo arithmetic, wraps both ways
  always_comb begin
    next_count = count;
    if (add_en) begin
      next_count = CNT_W'(next_count + add_val);
    end
    if (sub_en) begin
      next_count = CNT_W'(next_count - sub_val);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  wrap_add_a: assert property (@(posedge clock) disable iff (!nrst)
    add_en && !sub_en |=> count == CNT_W'($past(count) + $past(add_val)))
    else $error("free count add wrong");
  frame_sub_a: assert property (@(posedge clock) disable iff (!nrst)
    sub_en && !add_en |=> count == CNT_W'($past(count) - $past(sub_val)))
    else $error("free count subtract wrong");
  hold_idle_a: assert property (@(posedge clock) disable iff (!nrst)
    !add_en && !sub_en |=> $stable(count))
    else $error("free count moved without cause");

endmodule : rfb_free_counter

// >>> hw/rfb_top.sv
// rfb_top: receive free-buffer accounting and mac configuration.
// assumes ahb-lite master, frame-done events from the receive dma,
// and idle-reached indication from the mac core, all on clock.
`timescale 1ns/10ps
// Functional notes
// - writes add to 16-bit free count
// - count wraps around modulo 16 bits on overflow, keeping the excess
// - compare count with low-priority filter threshold
// - compare count with channel flow threshold
// - each frame subtracts its buffers used
// - one independent counter per channel
// - bit 14 blocks offset/length writes
// - bit 13 gives written ownership value
// - bit 12 enables fifo pause frames
// - bit 11 requests idle, status reports
// - bit 9 selects fixed or round-robin
// - bit 5 releases media interface reset
// - bit 4 honours pause in full duplex
// - bit 3 collision or pause on flow
module rfb_top #(
  parameter int unsigned CHANNELS = rfb_pkg::RFB_CHANNELS
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire rfb_pkg::rfb_frame_t frame_done,
  input wire logic frame_low_prio,
  input wire logic fifo_flow_trigger,
  input wire logic idle_reached,
  output logic filter_low_prio,
  output logic [CHANNELS-1:0] chan_flow_active,
  output logic send_pause,
  output logic force_collision,
  output rfb_pkg::rfb_ctl_t ctl,
  output logic desc_offlen_write_ok,
  output logic desc_owner_value,
  output logic tx_fixed_priority,
  output logic media_interface_reset,
  output logic pause_honor,
  output logic idle_status
);
  import rfb_pkg::*;

  localparam int unsigned CH_W = $clog2(RFB_CHANNELS);

  // ==========================================================
  // bus front end
  logic wr_en;
  logic rd_en;
  logic [11:0] acc_addr;

  rfb_ahb_slave u_bus (
    .clock(clock),
    .nrst(nrst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .acc_addr(acc_addr)
  );

  function automatic logic in_bank(input logic [11:0] a,
                                   input logic [11:0] base);
    in_bank = (a >= base) &&
      (a < 12'(base + 12'(CHANNELS) * RFB_CHAN_STRIDE));
  endfunction : in_bank

  function automatic logic [CH_W-1:0] bank_idx(input logic [11:0] a,
                                               input logic [11:0] base);
    logic [11:0] d;
    d = 12'(a - base);
    bank_idx = d[CH_W+1:2];
  endfunction : bank_idx

  // ==========================================================
  // configuration register
  logic [RFB_CFG_W-1:0] cfg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cfg <= RFB_CFG_RESET;
    end else if (wr_en && acc_addr == RFB_CFG_OFF) begin
      cfg <= hwdata[RFB_CFG_W-1:0] & RFB_CFG_MASK;
    end
  end

  assign ctl.offlen_block = cfg[RFB_B_OFFLEN];
  assign ctl.owner_value = cfg[RFB_B_OWNER];
  assign ctl.fifo_pause = cfg[RFB_B_FIFOPAUSE];
  assign ctl.idle_req = cfg[RFB_B_IDLE];
  assign ctl.tx_fixed_prio = cfg[RFB_B_TXPOL];
  assign ctl.tx_pace = cfg[RFB_B_PACE];
  assign ctl.mii_enable = cfg[RFB_B_MII];
  assign ctl.pause_honor = cfg[RFB_B_PAUSEHON];
  assign ctl.buf_flow = cfg[RFB_B_BUFFLOW];
  assign ctl.loopback = cfg[RFB_B_LOOP];
  assign ctl.fdx = cfg[RFB_B_FDX];

  // loopback forces internal full duplex
  logic duplex_full;
  assign duplex_full = ctl.fdx | ctl.loopback;

  assign desc_offlen_write_ok = ~ctl.offlen_block;
  assign desc_owner_value = ctl.owner_value;
  assign tx_fixed_priority = ctl.tx_fixed_prio;
  assign media_interface_reset = ~ctl.mii_enable;
  assign pause_honor = ctl.pause_honor & duplex_full;

  // ==========================================================
  // thresholds
  logic [RFB_THR_W-1:0] filt_thr;
  logic [RFB_THR_W-1:0] flow_thr [CHANNELS];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      filt_thr <= '0;
    end else if (wr_en && acc_addr == RFB_FILT_OFF) begin
      filt_thr <= hwdata[RFB_THR_W-1:0];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < CHANNELS; i++) begin
        flow_thr[i] <= '0;
      end
    end else if (wr_en && in_bank(acc_addr, RFB_FLOW_BASE)) begin
      flow_thr[bank_idx(acc_addr, RFB_FLOW_BASE)] <=
        hwdata[RFB_THR_W-1:0];
    end
  end

  // ==========================================================
  // free-buffer counters
  logic [RFB_CNT_W-1:0] free_cnt [CHANNELS];
  logic free_wr;
  logic [CH_W-1:0] free_idx;

  assign free_wr = wr_en && in_bank(acc_addr, RFB_FREE_BASE);
  assign free_idx = bank_idx(acc_addr, RFB_FREE_BASE);

  for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
    rfb_free_counter #(
      .CNT_W(RFB_CNT_W)
    ) u_cnt (
      .clock(clock),
      .nrst(nrst),
      .add_en(free_wr && free_idx == CH_W'(g)),
      .add_val(hwdata[RFB_CNT_W-1:0]),
      .sub_en(frame_done.valid && frame_done.chan == CH_W'(g)),
      .sub_val(frame_done.used),
      .count(free_cnt[g])
    );
  end

  // ==========================================================
  // threshold comparisons
  logic [CHANNELS-1:0] below_flow;
  logic [CHANNELS-1:0] below_filt;
  logic any_flow;

  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      below_flow[i] = free_cnt[i] < RFB_CNT_W'(flow_thr[i]);
      below_filt[i] = free_cnt[i] < RFB_CNT_W'(filt_thr);
    end
  end

  assign any_flow = |below_flow;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      chan_flow_active <= '0;
      filter_low_prio <= 1'b0;
    end else begin
      chan_flow_active <= below_flow & {CHANNELS{ctl.buf_flow}};
      filter_low_prio <= frame_low_prio &
        below_filt[frame_done.chan];
    end
  end

  // ==========================================================
  // pause and collision generation
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      send_pause <= 1'b0;
      force_collision <= 1'b0;
    end else begin
      send_pause <= duplex_full &&
        ((ctl.fifo_pause && fifo_flow_trigger) ||
         (ctl.buf_flow && any_flow));
      force_collision <= !duplex_full && ctl.buf_flow && any_flow;
    end
  end

  // ==========================================================
  // idle status
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      idle_status <= 1'b0;
    end else begin
      idle_status <= ctl.idle_req & idle_reached;
    end
  end

  // ==========================================================
  // read mux, registered into the data phase
  // reads decode their own address phase, so a write's held address
  // cannot steer a read issued back to back behind it
  logic [11:0] rd_addr;
  logic [31:0] next_rdata;

  assign rd_addr = {haddr[11:2], 2'b00};

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (in_bank(rd_addr, RFB_FREE_BASE)) begin
      next_rdata[RFB_CNT_W-1:0] =
        free_cnt[bank_idx(rd_addr, RFB_FREE_BASE)];
    end else if (in_bank(rd_addr, RFB_FLOW_BASE)) begin
      next_rdata[RFB_THR_W-1:0] =
        flow_thr[bank_idx(rd_addr, RFB_FLOW_BASE)];
    end else begin
      case (rd_addr)
        RFB_FILT_OFF: next_rdata[RFB_THR_W-1:0] = filt_thr;
        RFB_CFG_OFF: next_rdata[RFB_CFG_W-1:0] = cfg;
        RFB_STAT_OFF: next_rdata[RFB_S_IDLE] = idle_status;
        RFB_PRESS_OFF: next_rdata[CHANNELS-1:0] = chan_flow_active;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_en) begin
      hrdata <= next_rdata;
    end
  end

  // ==========================================================
  // checks
  offlen_block_a: assert property (@(posedge clock) disable iff (!nrst)
    desc_offlen_write_ok == !cfg[RFB_B_OFFLEN])
    else $error("offset/length block wrong");
  owner_value_a: assert property (@(posedge clock) disable iff (!nrst)
    desc_owner_value == cfg[RFB_B_OWNER])
    else $error("owner value wrong");
  fifo_pause_a: assert property (@(posedge clock) disable iff (!nrst)
    !cfg[RFB_B_FIFOPAUSE] && !cfg[RFB_B_BUFFLOW] |=> !send_pause)
    else $error("pause sent while disabled");
  fifo_send_a: assert property (@(posedge clock) disable iff (!nrst)
    duplex_full && ctl.fifo_pause && fifo_flow_trigger |=> send_pause)
    else $error("fifo pause not sent");
  send_half_a: assert property (@(posedge clock) disable iff (!nrst)
    !duplex_full |=> !send_pause)
    else $error("pause sent in half duplex");
  idle_report_a: assert property (@(posedge clock) disable iff (!nrst)
    cfg[RFB_B_IDLE] && idle_reached |=> idle_status)
    else $error("idle not reported");
  idle_clear_a: assert property (@(posedge clock) disable iff (!nrst)
    !cfg[RFB_B_IDLE] |=> !idle_status)
    else $error("idle reported without request");
  tx_policy_a: assert property (@(posedge clock) disable iff (!nrst)
    tx_fixed_priority == cfg[RFB_B_TXPOL])
    else $error("tx policy wrong");
  mii_reset_a: assert property (@(posedge clock) disable iff (!nrst)
    media_interface_reset != cfg[RFB_B_MII])
    else $error("media reset wrong");
  pause_half_a: assert property (@(posedge clock) disable iff (!nrst)
    !cfg[RFB_B_FDX] && !cfg[RFB_B_LOOP] |-> !pause_honor)
    else $error("pause honoured in half duplex");
  pause_full_a: assert property (@(posedge clock) disable iff (!nrst)
    cfg[RFB_B_FDX] && cfg[RFB_B_PAUSEHON] |-> pause_honor)
    else $error("pause not honoured in full duplex");
  collide_half_a: assert property (@(posedge clock)
    disable iff (!nrst)
    cfg[RFB_B_BUFFLOW] && !duplex_full && any_flow |=> force_collision)
    else $error("no forced collision");
  flow_compare_a: assert property (@(posedge clock) disable iff (!nrst)
    ctl.buf_flow && free_cnt[0] < RFB_CNT_W'(flow_thr[0])
    |=> chan_flow_active[0])
    else $error("flow not raised");
  flow_off_a: assert property (@(posedge clock) disable iff (!nrst)
    !ctl.buf_flow |=> chan_flow_active == '0)
    else $error("flow raised while disabled");
  filter_hit_a: assert property (@(posedge clock) disable iff (!nrst)
    frame_low_prio && free_cnt[frame_done.chan] < RFB_CNT_W'(filt_thr)
    |=> filter_low_prio)
    else $error("low priority frame not filtered");
  filter_miss_a: assert property (@(posedge clock) disable iff (!nrst)
    !frame_low_prio |=> !filter_low_prio)
    else $error("filter without low priority frame");
  cfg_write_a: assert property (@(posedge clock) disable iff (!nrst)
    wr_en && acc_addr == RFB_CFG_OFF
    |=> cfg == ($past(hwdata[RFB_CFG_W-1:0]) & RFB_CFG_MASK))
    else $error("config write lost");
  cfg_zero_a: assert property (@(posedge clock) disable iff (!nrst)
    (cfg & ~RFB_CFG_MASK) == '0)
    else $error("reserved config bit set");
  rd_zero_a: assert property (@(posedge clock) disable iff (!nrst)
    rd_en && rd_addr == RFB_CFG_OFF |=> hrdata[31:RFB_CFG_W] == '0)
    else $error("reserved config bits read back");

  // ==========================================================
  // per-channel flow checks
  for (genvar c = 0; c < CHANNELS; c++) begin : g_flow_chk
    chan_flow_a: assert property (@(posedge clock) disable iff (!nrst)
      ctl.buf_flow && free_cnt[c] < RFB_CNT_W'(flow_thr[c])
      |=> chan_flow_active[c])
      else $error("channel flow not raised");
    chan_calm_a: assert property (@(posedge clock) disable iff (!nrst)
      free_cnt[c] >= RFB_CNT_W'(flow_thr[c]) |=> !chan_flow_active[c])
      else $error("channel flow raised");
  end

  free_write_c: cover property (@(posedge clock) disable iff (!nrst)
    free_wr);
  filter_hit_c: cover property (@(posedge clock) disable iff (!nrst)
    filter_low_prio);
  frame_done_c: cover property (@(posedge clock) disable iff (!nrst)
    frame_done.valid ##1 chan_flow_active != '0);
  pause_sent_c: cover property (@(posedge clock) disable iff (!nrst)
    send_pause);
  idle_seen_c: cover property (@(posedge clock) disable iff (!nrst)
    idle_status);

endmodule : rfb_top

// >>> tb/testbench.sv
// testbench: self-checking bench for the free-buffer and mac config block.
// assumes rfb_pkg compiled first; one 100 MHz clock, ahb-lite register bus.
`timescale 1ns/10ps
module testbench;
  import rfb_pkg::*;
  // ==========================================================
  // signals
  logic clock, nrst, hsel, hwrite, hready, hreadyout, hresp;
  logic frame_low_prio, fifo_flow_trigger, idle_reached, look, lsel;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, ow;
  rfb_frame_t frame_done;
  rfb_ctl_t ctl;
  logic filter_low_prio, send_pause, force_collision, desc_offlen_write_ok;
  logic desc_owner_value, tx_fixed_priority, media_interface_reset;
  logic pause_honor, idle_status;
  logic [7:0] chan_flow_active;
  logic [15:0] cnt [8];
  logic [7:0] thr [8];
  logic [14:0] cfg;
  logic [31:0] exp_q [$];
  string nm_q [$];
  int n_fail, total_checks;

  assign hready = hreadyout;
  assign ow = {2'h0, hreadyout, hresp, ctl, filter_low_prio, send_pause,
    force_collision, desc_offlen_write_ok, desc_owner_value,
    tx_fixed_priority, media_interface_reset, pause_honor, idle_status,
    chan_flow_active};

  rfb_top rfb_top_i (.clock, .nrst, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .frame_done,
    .frame_low_prio, .fifo_flow_trigger, .idle_reached, .filter_low_prio,
    .chan_flow_active, .send_pause, .force_collision, .ctl,
    .desc_offlen_write_ok, .desc_owner_value, .tx_fixed_priority,
    .media_interface_reset, .pause_honor, .idle_status);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ==========================================================
  // expectations and comparison
  function automatic logic [31:0] outs(input logic filt);
    logic fd;
    logic [7:0] fl;
    fd = cfg[RFB_B_FDX] | cfg[RFB_B_LOOP];
    for (int i = 0; i < 8; i++) begin
      fl[i] = cfg[RFB_B_BUFFLOW] & (cnt[i] < {8'h00, thr[i]});
    end
    outs = {2'h0, 2'b10, cfg[14:11], cfg[9], cfg[6:3], cfg[1:0], filt,
      fd & (cfg[RFB_B_FIFOPAUSE] & fifo_flow_trigger | (|fl)),
      ~fd & (|fl), ~cfg[RFB_B_OFFLEN], cfg[RFB_B_OWNER], cfg[RFB_B_TXPOL],
      ~cfg[RFB_B_MII], cfg[RFB_B_PAUSEHON] & fd,
      cfg[RFB_B_IDLE] & idle_reached, fl};
  endfunction : outs

  function automatic logic [11:0] fa(input int ch);
    fa = RFB_FREE_BASE + RFB_CHAN_STRIDE * 12'(ch);
  endfunction : fa

  task check(input string nm, input logic [31:0] seen, input logic [31:0] e);
    total_checks++;
    if (seen !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, seen);
    end
  endtask : check

  task note(input string nm, input logic [31:0] e);
    exp_q.push_back(e);
    nm_q.push_back(nm);
  endtask : note

  always @(posedge clock) begin
    if (look === 1'b1 && exp_q.size() > 0) begin
      check(nm_q.pop_front(), lsel ? ow : hrdata, exp_q.pop_front());
    end
  end

  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (40000) @(posedge clock);
    n_fail++;
    wrap_up();
  end

  // ==========================================================
  // drivers
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    look <= ~w;
    lsel <= 1'b0;
    do @(posedge clock); while (hready !== 1'b1);
    look <= 1'b0;
  endtask : bus

  task wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    note(nm, e);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd

  task wrcfg(input logic [14:0] c);
    wr(RFB_CFG_OFF, {17'h0, c});
    cfg = c & RFB_CFG_MASK;
  endtask : wrcfg

  task probe(input int wt, input logic filt);
    repeat (wt) @(posedge clock);
    note("outputs", outs(filt));
    look <= 1'b1;
    lsel <= 1'b1;
    @(posedge clock);
    look <= 1'b0;
  endtask : probe

  task frame(input int ch, input logic [15:0] u, input logic lp);
    frame_done <= {1'b1, 3'(ch), u};
    frame_low_prio <= lp;
    @(posedge clock);
    frame_done <= '0;
    frame_low_prio <= 1'b0;
    cnt[ch] = cnt[ch] - u;
    if (!lp) @(posedge clock);
  endtask : frame

  // ==========================================================
  // main sequence
  initial begin
    nrst = 1'b0;
    {hsel, hwrite, frame_low_prio, fifo_flow_trigger} = 4'h0;
    {idle_reached, look, lsel} = 3'h0;
    haddr = 12'h000;
    htrans = 2'b00;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    frame_done = '0;
    cfg = 15'h0000;
    n_fail = 0;
    total_checks = 0;
    foreach (cnt[i]) begin
      cnt[i] = 16'h0000;
      thr[i] = 8'h00;
    end
    void'($urandom(40));
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    probe(1, 1'b0);
    rd(RFB_CFG_OFF, 32'h0000_0000, "config");
    wr(12'h080, 32'hffff_ffff);
    rd(12'h080, 32'h0000_0000, "unmapped");
    for (int j = 0; j < 2; j++) begin
      for (int ch = 0; ch < 8; ch++) begin
        logic [15:0] v;
        v = 16'($urandom);
        wr(fa(ch), {16'h0000, v});
        cnt[ch] = cnt[ch] + v;
      end
    end
    for (int ch = 0; ch < 8; ch++) begin
      rd(fa(ch), {16'h0, cnt[ch]}, "free");
    end
    wr(fa(0), {16'h0000, ~cnt[0]});
    wr(fa(0), 32'h0000_0003);
    cnt[0] = 16'h0002;
    rd(fa(0), 32'h0000_0002, "wrap");
    for (int ch = 0; ch < 8; ch++) frame(ch, 16'($urandom) & cnt[ch], 1'b0);
    frame(2, cnt[2] - 16'h0005, 1'b0);
    for (int ch = 0; ch < 8; ch++) begin
      rd(fa(ch), {16'h0, cnt[ch]}, "used");
    end
    idle_reached <= 1'b1;
    for (int i = 0; i < 15; i++) begin
      wrcfg(15'h0001 << i);
      rd(RFB_CFG_OFF, {17'h0, cfg}, "config");
      probe(2, 1'b0);
    end
    thr[0] = 8'h0a;
    wr(RFB_FLOW_BASE, 32'h0000_000a);
    thr[2] = 8'h0a;
    wr(RFB_FLOW_BASE + 12'h008, 32'h0000_000a);
    wrcfg(15'h0009);
    probe(2, 1'b0);
    rd(RFB_PRESS_OFF, 32'h0000_0005, "flow");
    wrcfg(15'h0008);
    probe(2, 1'b0);
    wrcfg(15'h000a);
    probe(2, 1'b0);
    fifo_flow_trigger <= 1'b1;
    wrcfg(15'h1001);
    probe(2, 1'b0);
    wrcfg(15'h1000);
    probe(2, 1'b0);
    wr(RFB_FILT_OFF, 32'h0000_0006);
    frame(2, 16'h0000, 1'b1);
    probe(0, 1'b1);
    wr(RFB_FILT_OFF, 32'h0000_0005);
    frame(2, 16'h0000, 1'b1);
    probe(0, 1'b0);
    wrcfg(15'h0800);
    probe(2, 1'b0);
    rd(RFB_STAT_OFF, 32'h0000_0001, "status");
    idle_reached <= 1'b0;
    probe(2, 1'b0);
    rd(RFB_STAT_OFF, 32'h0000_0000, "status");
    wrcfg(15'h0008);
    probe(2, 1'b0);
    wr(fa(2), 32'h0000_0007);
    cnt[2] = cnt[2] + 16'h0007;
    probe(2, 1'b0);
    rd(fa(2), {16'h0, cnt[2]}, "free");
    wrap_up();
  end
endmodule : testbench
